// ==== core/adcc_ctrl.sv ====
// Converter control: registers, start/abort, completion flag, low-power and stop behaviour
//
// Notes on behaviour
// R1: Sample phase lasts 3.5 converter cycles, or 23.5 with long sampling.
// R2: Results come at 8 or 10 bits; 10-bit gives 1024 codes.
// R3: With interrupt enabled, request rises when a conversion completes and flag sets.
// R4: Completion flag sets at every completed conversion, interrupt enabled or not; the code does not set it when a half-read 10-bit result is dropped as lost.
// R5: Wait mode changes nothing: conversions and completion requests continue.
// R6: Channel field written all ones shuts the core into low power.
// R7: Stop without async clock aborts conversion and enters low power.
// R8: After such a stop, only a control register write restarts converting.
// R9: An aborted conversion leaves the result registers at the last result.
// R10: Stop with async clock enabled: conversions and interrupts continue normally.
// R11: Single mode returns to low power after each completed conversion.
// R12: Stop, async clock, hardware mode: idle until trigger, then one conversion.
// R13: A hardware-triggered conversion in stop raises the completion request.
// R14: Software should clear continuous mode before stop unless wake-ups are wanted.
// R15: Control write or low result read clears the completion flag.
// R16: Result read or control write withdraws the completion request.
// R17: Software mode: control write with channel not all ones starts conversion.
// R18: Flag and request live in flip-flops of the bus clock, glitch free.
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl #(
    parameter int HALF_CYC = adcc_pkg::CONV_HALF_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire adcc_pkg::adcc_bus_s i_bus,
    output logic [7:0] o_rdata,
    input wire logic i_stop_mode,
    input wire logic i_hw_trigger,
    input wire logic i_cmp_high,
    output logic [9:0] o_dac,
    output logic [4:0] o_channel,
    output logic o_core_power_on,
    output logic o_sampling,
    output logic o_irq
);
    import adcc_pkg::*;

    // ******************************
    // State and submodule wiring
    // ******************************
    adcc_ctrl_s r;
    adcc_ctrl_s next_r;
    logic sar_busy;
    logic sar_done;
    logic [9:0] sar_result;
    logic tick;
    logic ch_off;
    logic stop_kill;
    logic wr_scr;
    logic wr_cfg;
    logic rd_lo;
    logic rd_hi;
    logic [7:0] w;

    adcc_tick_div #(
        .HALF_CYC(HALF_CYC)
    ) u_div (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        // A restart re-aligns the divider, so every sample window of one sampling setting has the same length
        .i_run(sar_busy && !r.start),
        .o_tick(tick)
    );

    adcc_sar u_sar (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_tick(tick),
        .i_start(r.start),
        .i_abort(r.abort),
        .i_long(r.long_smp),
        .i_ten_bit(r.ten_bit),
        .i_cmp_high(i_cmp_high),
        .o_busy(sar_busy),
        .o_sampling(o_sampling),
        .o_done(sar_done),
        .o_result(sar_result),
        .o_dac(o_dac)
    );

    // ******************************
    // Decodes
    // ******************************
    assign w = i_bus.wdata;
    assign ch_off = (r.channel == CHANNEL_OFF);
    assign wr_scr = i_bus.wr && (i_bus.addr == OFF_SCR);
    assign wr_cfg = i_bus.wr && (i_bus.addr == OFF_CFG);
    assign rd_lo = i_bus.rd && (i_bus.addr == OFF_RES_LO);
    assign rd_hi = i_bus.rd && (i_bus.addr == OFF_RES_HI);
    // Stop only kills the converter when it has no clock of its own
    assign stop_kill = i_stop_mode && !r.aclk_en; // [R7] [R10]

    // ******************************
    // Next-state logic
    // ******************************
    always_comb begin
        next_r = r;
        next_r.start = 1'b0;
        next_r.abort = 1'b0;
        next_r.rdata = 8'h00;

        // Read path; data stand only in the cycle after the strobe
        if (i_bus.rd) begin
            case (i_bus.addr)
                OFF_SCR: begin
                    next_r.rdata = {r.flag, r.irq_en, r.cont_en, r.channel};
                end
                OFF_RES_HI: begin
                    next_r.rdata = {6'h00, r.result[9:8]};
                end
                OFF_RES_LO: begin
                    next_r.rdata = r.result[7:0];
                end
                OFF_CFG: begin
                    next_r.rdata = {4'h0, r.aclk_en, r.hw_sel, r.ten_bit, r.long_smp};
                end
                OFF_EVT_STATUS: begin
                    next_r.rdata = {5'h00, r.evt_status};
                end
                OFF_EVT_MASK: begin
                    next_r.rdata = {5'h00, r.evt_mask};
                end
                default: begin
                    next_r.rdata = 8'h00;
                end
            endcase
        end

        // Reading the high byte in 10-bit mode locks the pair until low is read
        if (rd_hi && r.ten_bit) begin
            next_r.hi_read_pend = 1'b1;
        end
        if (rd_lo) begin
            next_r.hi_read_pend = 1'b0;
            next_r.flag = 1'b0; // [R15]
        end
        if (rd_lo || rd_hi) begin
            next_r.irq_req = 1'b0; // [R16]
        end

        // Control register write: abort, then restart in software mode unless channel is off
        if (wr_scr) begin
            next_r.irq_en = w[SCR_IRQ_EN_BIT];
            next_r.cont_en = w[SCR_CONT_BIT];
            next_r.channel = w[4:0];
            next_r.flag = 1'b0; // [R15]
            next_r.irq_req = 1'b0; // [R16]
            next_r.abort = 1'b1;
            next_r.run = (w[4:0] != CHANNEL_OFF); // [R6] [R8]
            if (!r.hw_sel && (w[4:0] != CHANNEL_OFF)) begin
                next_r.start = 1'b1; // [R17]
            end
        end

        // Configuration write aborts and leaves the converter idle
        if (wr_cfg) begin
            next_r.long_smp = w[CFG_LONG_BIT];
            next_r.ten_bit = w[CFG_TEN_BIT];
            next_r.hw_sel = w[CFG_HW_BIT];
            next_r.aclk_en = w[CFG_ACLK_BIT];
            next_r.abort = 1'b1;
            next_r.run = 1'b0;
        end

        // Hardware trigger works in run, wait and (with async clock) stop
        if (r.hw_sel && r.run && !ch_off && !sar_busy && !r.start && i_hw_trigger
            && !i_bus.wr) begin
            next_r.start = 1'b1; // [R12]
        end

        // Event status is write-one-to-clear; events applied below win in the same cycle
        if (i_bus.wr && (i_bus.addr == OFF_EVT_STATUS)) begin
            next_r.evt_status = r.evt_status & ~w[2:0];
        end

        // Completion; set wins over any clear in the same cycle
        if (sar_done && !r.abort) begin
            if (r.hi_read_pend && r.ten_bit && !rd_lo) begin
                // Pair is half read: result dropped, a new conversion goes anyway
                next_r.evt_status[EVT_LOST_BIT] = 1'b1;
                next_r.start = !wr_scr && !wr_cfg;
            end else begin
                next_r.result = sar_result; // [R9]
                next_r.flag = 1'b1; // [R4] [R18]
                // Wait mode has no input here: it cannot hold the request back
                if (r.irq_en) begin
                    next_r.irq_req = 1'b1; // [R3] [R5] [R13]
                end
                next_r.evt_status[EVT_DONE_BIT] = 1'b1;
                if (r.cont_en && r.run && !ch_off && !wr_scr && !wr_cfg) begin
                    next_r.start = 1'b1;
                end else if (!r.cont_en && !r.hw_sel && !wr_scr) begin
                    next_r.run = 1'b0; // [R11]
                end
            end
        end

        // Stop without async clock: abort, drop the run state, no restart
        if (stop_kill) begin
            if (sar_busy || r.start) begin
                next_r.evt_status[EVT_ABORT_BIT] = 1'b1;
            end
            next_r.abort = 1'b1; // [R7]
            next_r.start = 1'b0;
            next_r.run = 1'b0; // [R8]
        end

        if (i_bus.wr && (i_bus.addr == OFF_EVT_MASK)) begin
            next_r.evt_mask = w[2:0];
        end
    end

    // ******************************
    // State register
    // ******************************
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r <= '0;
            r.channel <= RST_CHANNEL;
            r.ten_bit <= RST_TEN_BIT;
            r.result <= RST_RESULT;
        end else begin
            r <= next_r;
        end
    end

    // ******************************
    // Outputs
    // ******************************
    assign o_rdata = r.rdata;
    assign o_channel = r.channel;
    // Core is powered only while a conversion runs; otherwise it sits in low power
    assign o_core_power_on = sar_busy; // [R6] [R11]
    assign o_irq = r.irq_req || (|(r.evt_status & r.evt_mask)); // [R3] [R18]
endmodule
`default_nettype wire

// ==== core/adcc_pkg.sv ====
// Shared constants, types and state records of the converter control block
package adcc_pkg;

    // ******************************
    // Register map (word index on the plain register port)
    // ******************************
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFF_SCR = 3'h0;
    localparam logic [2:0] OFF_RES_HI = 3'h1;
    localparam logic [2:0] OFF_RES_LO = 3'h2;
    localparam logic [2:0] OFF_CFG = 3'h3;
    localparam logic [2:0] OFF_EVT_STATUS = 3'h4;
    localparam logic [2:0] OFF_EVT_MASK = 3'h5;

    // ******************************
    // Field positions
    // ******************************
    localparam int SCR_FLAG_BIT = 7;
    localparam int SCR_IRQ_EN_BIT = 6;
    localparam int SCR_CONT_BIT = 5;
    localparam int CFG_LONG_BIT = 0;
    localparam int CFG_TEN_BIT = 1;
    localparam int CFG_HW_BIT = 2;
    localparam int CFG_ACLK_BIT = 3;
    localparam int EVT_DONE_BIT = 0;
    localparam int EVT_ABORT_BIT = 1;
    localparam int EVT_LOST_BIT = 2;
    localparam int EVT_W = 3;
    localparam logic [4:0] CHANNEL_OFF = 5'h1F;

    // ******************************
    // Reset values
    // ******************************
    localparam logic [4:0] RST_CHANNEL = 5'h1F;
    localparam logic RST_TEN_BIT = 1'b1;
    localparam logic [9:0] RST_RESULT = 10'h000;

    // ******************************
    // Timing
    // ******************************
    localparam int MCLK_PERIOD_PS = 5000;
    localparam int CONV_HALF_PERIOD_PS = 250000;
    localparam int CONV_HALF_CYC = (CONV_HALF_PERIOD_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    localparam logic [5:0] SAMPLE_SHORT_HALVES = 6'h07;
    localparam logic [5:0] SAMPLE_LONG_HALVES = 6'h2F;
    localparam logic [3:0] TOP_BIT_IDX = 4'h9;
    localparam logic [3:0] LAST_IDX_TEN = 4'h0;
    localparam logic [3:0] LAST_IDX_EIGHT = 4'h2;

    // ******************************
    // Types
    // ******************************
    typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_CONVERT} adcc_phase_e;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } adcc_bus_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } adcc_div_s;

    typedef struct packed {
        adcc_phase_e phase;
        logic [5:0] cnt;
        logic [3:0] idx;
        logic [9:0] code;
        logic [9:0] dac;
        logic [9:0] result;
        logic done;
    } adcc_sar_s;

    typedef struct packed {
        logic irq_en;
        logic cont_en;
        logic [4:0] channel;
        logic flag;
        logic irq_req;
        logic long_smp;
        logic ten_bit;
        logic hw_sel;
        logic aclk_en;
        logic [9:0] result;
        logic hi_read_pend;
        logic run;
        logic [2:0] evt_status;
        logic [2:0] evt_mask;
        logic [7:0] rdata;
        logic start;
        logic abort;
    } adcc_ctrl_s;

endpackage

// ==== core/adcc_tick_div.sv ====
// Half-period tick generator standing in for the converter clock
`timescale 1ns/1ps
`default_nettype none
module adcc_tick_div #(
    parameter int HALF_CYC = adcc_pkg::CONV_HALF_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_run,
    output logic o_tick
);
    import adcc_pkg::*;

    adcc_div_s r;
    adcc_div_s next_r;

    // Counter parks at zero while idle so the converter clock is off in low power
    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (!i_run) begin
            next_r.cnt = 16'h0000;
        end else if (r.cnt == 16'(HALF_CYC - 1)) begin
            next_r.cnt = 16'h0000;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_tick = r.tick;
endmodule
`default_nettype wire

// ==== core/adcc_sar.sv ====
// Successive-approximation sequencer: sample window then one bit per converter cycle
`timescale 1ns/1ps
`default_nettype none
module adcc_sar (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic i_long,
    input wire logic i_ten_bit,
    input wire logic i_cmp_high,
    output logic o_busy,
    output logic o_sampling,
    output logic o_done,
    output logic [9:0] o_result,
    output logic [9:0] o_dac
);
    import adcc_pkg::*;

    adcc_sar_s r;
    adcc_sar_s next_r;
    logic [9:0] kept;
    logic [3:0] last_idx;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        kept = i_cmp_high ? r.dac : r.code;
        last_idx = i_ten_bit ? LAST_IDX_TEN : LAST_IDX_EIGHT; // [R2]
        if (i_start) begin
            // Sample window counted in half cycles: 7 or 47 halves
            next_r.phase = PH_SAMPLE;
            next_r.cnt = (i_long ? SAMPLE_LONG_HALVES : SAMPLE_SHORT_HALVES) - 6'h01; // [R1]
            next_r.code = 10'h000;
            next_r.dac = 10'h000;
        end else if (i_abort) begin
            next_r.phase = PH_IDLE;
            next_r.dac = 10'h000;
        end else if (i_tick) begin
            case (r.phase)
                PH_SAMPLE: begin
                    if (r.cnt == 6'h00) begin
                        next_r.phase = PH_CONVERT;
                        next_r.idx = TOP_BIT_IDX;
                        next_r.cnt = 6'h01;
                        next_r.dac = 10'h200;
                    end else begin
                        next_r.cnt = r.cnt - 6'h01;
                    end
                end
                PH_CONVERT: begin
                    if (r.cnt != 6'h00) begin
                        next_r.cnt = 6'h00;
                    end else if (r.idx == last_idx) begin
                        next_r.phase = PH_IDLE;
                        next_r.done = 1'b1;
                        next_r.dac = 10'h000;
                        next_r.result = i_ten_bit ? kept : {2'b00, kept[9:2]}; // [R2]
                    end else begin
                        next_r.idx = r.idx - 4'h1;
                        next_r.code = kept;
                        next_r.dac = kept | (10'h001 << (r.idx - 4'h1));
                        next_r.cnt = 6'h01;
                    end
                end
                default: begin
                    next_r.phase = PH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_busy = (r.phase != PH_IDLE);
    assign o_sampling = (r.phase == PH_SAMPLE);
    assign o_done = r.done;
    assign o_result = r.result;
    assign o_dac = r.dac;
endmodule
`default_nettype wire

// ==== verification/adcc_ctrl_monitor.sv ====
// Port-level concurrent checks for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_monitor
    import adcc_pkg::*;
#(
    parameter int HALF_CYC = 2
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire adcc_pkg::adcc_bus_s i_bus,
    input wire logic [7:0] o_rdata,
    input wire logic i_stop_mode,
    input wire logic i_hw_trigger,
    input wire logic i_cmp_high,
    input wire logic [9:0] o_dac,
    input wire logic [4:0] o_channel,
    input wire logic o_core_power_on,
    input wire logic o_sampling,
    input wire logic o_irq
);
    // ****************************************
    // Sample window and power-on length counters
    // ****************************************
    logic [15:0] smp_cnt;
    logic [15:0] pwr_cnt;
    logic scr_wr_q;
    // A control write restarts the window, so both counts start over with it
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            scr_wr_q <= 1'b0;
        end else begin
            scr_wr_q <= i_bus.wr && (i_bus.addr == OFF_SCR);
        end
        if (i_rst || !o_sampling || scr_wr_q) begin
            smp_cnt <= 16'h0000;
        end else begin
            smp_cnt <= smp_cnt + 16'h0001;
        end
        if (i_rst || !o_core_power_on || scr_wr_q) begin
            pwr_cnt <= 16'h0000;
        end else begin
            pwr_cnt <= pwr_cnt + 16'h0001;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // Aborted windows end with power off, so only full windows are measured
    // The divider needs one clock before its first tick, hence the extra clock
    a_sample_window_len: assert property ($fell(o_sampling) && o_core_power_on |->
        (smp_cnt == 7 * HALF_CYC + 1) || (smp_cnt == 47 * HALF_CYC + 1))
        else $error("sample window length wrong");
    a_dac_midscale_first: assert property ($fell(o_sampling) && o_core_power_on |->
        ##[0:1] (o_dac == 10'h200)) else $error("first trial code not midscale");
    a_irq_needs_done: assert property ($rose(o_irq) |-> $past(o_core_power_on, 2))
        else $error("interrupt rose without a conversion ending");
    a_off_stays_quiet: assert property ((o_channel == CHANNEL_OFF) &&
        $past(o_channel == CHANNEL_OFF) |-> !o_core_power_on)
        else $error("core powered while channel off");
    a_start_has_cause: assert property ($rose(o_core_power_on) |->
        $past(i_bus.wr, 2) || $past(i_hw_trigger, 2) || $past(i_hw_trigger, 3) ||
        $past(o_core_power_on, 3)) else $error("conversion started without cause");
    // Longest conversion: long window plus ten bits of two ticks each
    a_power_returns: assert property (pwr_cnt <= 67 * HALF_CYC + 1)
        else $error("core stayed powered past one conversion");
    a_channel_follows: assert property (i_bus.wr && (i_bus.addr == OFF_SCR) |=>
        o_channel == $past(i_bus.wdata[4:0])) else $error("channel not taken from write");
    a_rdata_idle_zero: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
        else $error("read data outside read cycle");

    c_conv_done: cover property ($fell(o_core_power_on) && o_irq);
    c_long_sample: cover property ($fell(o_sampling) && smp_cnt == 47 * HALF_CYC + 1);
    c_stop_abort: cover property (i_stop_mode && $fell(o_sampling));
endmodule
bind adcc_ctrl adcc_ctrl_monitor #(.HALF_CYC(HALF_CYC)) u_adcc_ctrl_monitor (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_bus(i_bus),
    .o_rdata(o_rdata),
    .i_stop_mode(i_stop_mode),
    .i_hw_trigger(i_hw_trigger),
    .i_cmp_high(i_cmp_high),
    .o_dac(o_dac),
    .o_channel(o_channel),
    .o_core_power_on(o_core_power_on),
    .o_sampling(o_sampling),
    .o_irq(o_irq)
);
`default_nettype wire

// ==== verification/test_adcc_ctrl.sv ====
// Register-level testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_adcc_ctrl;
    import adcc_pkg::*;
    localparam int HC = 2;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    adcc_bus_s bus = '0;
    logic stop = 1'b0;
    logic trig = 1'b0;
    logic [9:0] tgt = 10'h000;
    logic [7:0] rdata;
    logic [9:0] dac;
    logic [4:0] chan;
    logic pwr;
    logic smp;
    logic irq;
    wire logic cmp = (tgt >= dac);
    int err_total = 0;
    int num_checks = 0;
    int smp_acc = 0;
    int smp_len = 0;

    always #2.5 i_mclk = ~i_mclk;

    // Length in clocks of the last sample window, measured at the pin
    always @(posedge i_mclk) begin
        if (smp === 1'b1) begin
            smp_acc <= smp_acc + 1;
        end else begin
            if (smp_acc != 0) smp_len <= smp_acc;
            smp_acc <= 0;
        end
    end

    adcc_ctrl #(.HALF_CYC(HC)) u_adcc_ctrl (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_bus(bus),
        .o_rdata(rdata),
        .i_stop_mode(stop),
        .i_hw_trigger(trig),
        .i_cmp_high(cmp),
        .o_dac(dac),
        .o_channel(chan),
        .o_core_power_on(pwr),
        .o_sampling(smp),
        .o_irq(irq)
    );

    // ****************************************
    // Access and check tasks
    // ****************************************
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge i_mclk);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge i_mclk);
        bus.rd <= 1'b0;
        #1;
        chk({8'h00, rdata}, {8'h00, exp});
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    // Waits for power to come on and go off again, bounded
    task automatic wait_conv();
        bit seen;
        seen = 1'b0;
        for (int i = 0; i < 800; i++) begin
            @(posedge i_mclk);
            #1;
            if (pwr === 1'b1) seen = 1'b1;
            if (seen && pwr === 1'b0) begin
                cycles(1);
                return;
            end
        end
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        err_total++;
        summarize();
    endtask

    task automatic convert(input logic [7:0] scr, input logic [9:0] t);
        tgt = t;
        wr(OFF_SCR, scr);
        wait_conv();
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd(OFF_SCR, 8'h1F);
        rd(OFF_CFG, 8'h02);
        rd(OFF_RES_LO, 8'h00);
        rd(3'h6, 8'h00);
        chk(chan, CHANNEL_OFF);
        convert(8'h41, 10'h2A5);
        chk(irq, 1'b1);
        rd(OFF_SCR, 8'hC1);
        rd(OFF_RES_HI, 8'h02);
        rd(OFF_RES_LO, 8'hA5);
        chk(irq, 1'b0);
        rd(OFF_SCR, 8'h41);
        chk(pwr, 1'b0);
        convert(8'h01, 10'h133);
        chk(irq, 1'b0);
        rd(OFF_SCR, 8'h81);
        wr(OFF_SCR, 8'h1F);
        rd(OFF_SCR, 8'h1F);
        cycles(30);
        chk(pwr, 1'b0);
        wr(OFF_CFG, 8'h03);
        convert(8'h01, 10'h3FF);
        chk(16'(smp_len), 16'(47 * HC + 1));
        rd(OFF_RES_HI, 8'h03);
        rd(OFF_RES_LO, 8'hFF);
        wr(OFF_CFG, 8'h00);
        convert(8'h01, 10'h2A5);
        chk(16'(smp_len), 16'(7 * HC + 1));
        rd(OFF_RES_HI, 8'h00);
        rd(OFF_RES_LO, 8'hA9);
        wr(OFF_CFG, 8'h02);
        tgt = 10'h155;
        wr(OFF_SCR, 8'h01);
        cycles(10);
        stop <= 1'b1;
        cycles(4);
        chk(pwr, 1'b0);
        cycles(100);
        stop <= 1'b0;
        cycles(100);
        chk(pwr, 1'b0);
        rd(OFF_SCR, 8'h01);
        rd(OFF_RES_HI, 8'h00);
        rd(OFF_RES_LO, 8'hA9);
        convert(8'h01, 10'h155);
        rd(OFF_RES_HI, 8'h01);
        rd(OFF_RES_LO, 8'h55);
        wr(OFF_CFG, 8'h0A);
        stop <= 1'b1;
        convert(8'h41, 10'h0C3);
        chk(irq, 1'b1);
        rd(OFF_RES_LO, 8'hC3);
        wr(OFF_CFG, 8'h0E);
        tgt = 10'h0F0;
        wr(OFF_SCR, 8'h41);
        cycles(100);
        chk(pwr, 1'b0);
        trig <= 1'b1;
        cycles(3);
        trig <= 1'b0;
        wait_conv();
        chk(irq, 1'b1);
        rd(OFF_RES_LO, 8'hF0);
        stop <= 1'b0;
        wr(OFF_CFG, 8'h02);
        wr(OFF_EVT_STATUS, 8'h07);
        wr(OFF_EVT_MASK, 8'h01);
        rd(OFF_EVT_MASK, 8'h01);
        convert(8'h01, 10'h011);
        chk(irq, 1'b1);
        rd(OFF_EVT_STATUS, 8'h01);
        wr(OFF_EVT_STATUS, 8'h01);
        cycles(1);
        chk(irq, 1'b0);
        rd(OFF_EVT_STATUS, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
